// *** uied_regs.vh ***
`ifndef UIED_REGS_VH
`define UIED_REGS_VH
// Descriptor lengths and type codes.
`define UIED_IF_LEN 8'h09
`define UIED_IF_TYPE 8'h04
`define UIED_EP_LEN 8'h07
`define UIED_EP_TYPE 8'h05
// Interface descriptor fixed values.
`define UIED_IF_NUM 8'h00
`define UIED_IF_ALT 8'h00
`define UIED_IF_NEP 8'h03
// Interface descriptor defaults without EEPROM.
`define UIED_DEF_CLASS 8'hFF
`define UIED_DEF_SUBCLASS 8'h00
`define UIED_DEF_PROTO 8'hFF
`define UIED_DEF_STRIDX 8'h00
// Endpoint addresses and attributes.
`define UIED_EP1_ADDR 8'h81
`define UIED_EP2_ADDR 8'h02
`define UIED_EP3_ADDR 8'h83
`define UIED_ATTR_BULK 8'h02
`define UIED_ATTR_INTR 8'h03
`define UIED_BULK_IVL 8'h00
// Maximum packet sizes.
`define UIED_MPS_FS 16'h0040
`define UIED_MPS_HS 16'h0200
`define UIED_MPS_INTR 16'h0010
// Interrupt polling interval defaults.
`define UIED_DEF_IVL_HS 8'h04
`define UIED_DEF_IVL_FS 8'h01
// Response byte layout: interface then three endpoints.
`define UIED_IF_BASE 6'h00
`define UIED_EP1_BASE 6'h09
`define UIED_EP2_BASE 6'h10
`define UIED_EP3_BASE 6'h17
`define UIED_TOTAL 6'h1E
// Interface descriptor field offsets.
`define UIED_IF_OFF_LEN 6'h00
`define UIED_IF_OFF_TYPE 6'h01
`define UIED_IF_OFF_NUM 6'h02
`define UIED_IF_OFF_ALT 6'h03
`define UIED_IF_OFF_NEP 6'h04
`define UIED_IF_OFF_CLASS 6'h05
`define UIED_IF_OFF_SUBCLASS 6'h06
`define UIED_IF_OFF_PROTO 6'h07
`define UIED_IF_OFF_STRIDX 6'h08
// Endpoint descriptor field offsets.
`define UIED_EP_OFF_LEN 3'h0
`define UIED_EP_OFF_TYPE 3'h1
`define UIED_EP_OFF_ADDR 3'h2
`define UIED_EP_OFF_ATTR 3'h3
`define UIED_EP_OFF_MPSL 3'h4
`define UIED_EP_OFF_MPSH 3'h5
`define UIED_EP_OFF_IVL 3'h6
// Descriptor selectors carried on the request pointer.
`define UIED_SEL_ALL 3'h0
`define UIED_SEL_IF 3'h1
`define UIED_SEL_EP1 3'h2
`define UIED_SEL_EP2 3'h3
`define UIED_SEL_EP3 3'h4
`endif

// *** uied_ep_byte.v ***
`timescale 1ns/1ps
`include "uied_regs.vh"
// Returns one byte of a seven-byte endpoint descriptor by offset.
module uied_ep_byte (
   input wire [2:0] offs,
   input wire [7:0] addr,
   input wire [7:0] attr,
   input wire [15:0] mps,
   input wire [7:0] ivl,
   output reg [7:0] data
);
   // Field order is length, type, address, attributes, size low, size high, interval.
   always @* begin
      case (offs)
         `UIED_EP_OFF_LEN: data = `UIED_EP_LEN;
         `UIED_EP_OFF_TYPE: data = `UIED_EP_TYPE;
         `UIED_EP_OFF_ADDR: data = addr;
         `UIED_EP_OFF_ATTR: data = attr;
         `UIED_EP_OFF_MPSL: data = mps[7:0];
         `UIED_EP_OFF_MPSH: data = mps[15:8];
         `UIED_EP_OFF_IVL: data = ivl;
         default: data = 8'h00;
      endcase
   end
endmodule

// *** uied_desc.v ***
`timescale 1ns/1ps
`include "uied_regs.vh"
// Operation
// - Interface descriptor nine bytes, fixed header fields.
// - Class bytes from EEPROM, else defaults.
// - Fixed bulk IN descriptor, address 81h.
// - Fixed bulk OUT descriptor, address 02h.
// - Bulk packet size 64 FS, 512 HS.
// - Fixed interrupt descriptor, address 83h, size 10h.
// - Interrupt interval per speed from EEPROM.
// - Interval defaults 04h HS, 01h FS.
// - Request pointer selects descriptor bytes returned.
module uied_desc (
   input wire clk,
   input wire sys_rst,
   input wire high_speed,
   input wire ee_load,
   input wire [7:0] ee_class,
   input wire [7:0] ee_subclass,
   input wire [7:0] ee_proto,
   input wire [7:0] ee_stridx,
   input wire [7:0] ee_ivl_hs,
   input wire [7:0] ee_ivl_fs,
   input wire req_valid,
   input wire [2:0] req_sel,
   input wire [5:0] req_len,
   input wire byte_ready,
   output reg byte_valid,
   output reg [7:0] byte_data,
   output reg byte_last
);
   // Fields that the EEPROM loader may overwrite.
   reg [7:0] class_q;
   reg [7:0] subclass_q;
   reg [7:0] proto_q;
   reg [7:0] stridx_q;
   reg [7:0] ivl_hs_q;
   reg [7:0] ivl_fs_q;
   reg busy_q;
   reg [5:0] idx_q;
   reg [5:0] end_q;
   reg hs_q;
   reg [5:0] start_d;
   reg [5:0] stop_d;
   reg [5:0] lim_d;
   reg [5:0] nidx_d;
   reg [7:0] if_byte;
   reg [7:0] pick_d;
   wire [7:0] ep1_byte;
   wire [7:0] ep2_byte;
   wire [7:0] ep3_byte;
   wire [15:0] bulk_mps;
   wire [7:0] intr_ivl;
   wire [5:0] rel1;
   wire [5:0] rel2;
   wire [5:0] rel3;

   // EEPROM-loaded fields, reset to the no-EEPROM defaults.
   // Header fields are not loaded: hardware holds them at their compliant values.
   always @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         class_q <= `UIED_DEF_CLASS;
         subclass_q <= `UIED_DEF_SUBCLASS;
         proto_q <= `UIED_DEF_PROTO;
         stridx_q <= `UIED_DEF_STRIDX;
         ivl_hs_q <= `UIED_DEF_IVL_HS;
         ivl_fs_q <= `UIED_DEF_IVL_FS;
      end else if (ee_load) begin
         class_q <= ee_class;
         subclass_q <= ee_subclass;
         proto_q <= ee_proto;
         stridx_q <= ee_stridx;
         ivl_hs_q <= ee_ivl_hs;
         ivl_fs_q <= ee_ivl_fs;
      end
   end

   // Speed-dependent fields; speed is latched per response so it cannot tear mid-stream.
   assign bulk_mps = hs_q ? `UIED_MPS_HS : `UIED_MPS_FS;
   assign intr_ivl = hs_q ? ivl_hs_q : ivl_fs_q;

   // Interface descriptor bytes; header fields are fixed in hardware.
   // Offsets past the interface window read as zero; the mux never selects them.
   always @* begin
      case (idx_q)
         `UIED_IF_OFF_LEN: if_byte = `UIED_IF_LEN;
         `UIED_IF_OFF_TYPE: if_byte = `UIED_IF_TYPE;
         `UIED_IF_OFF_NUM: if_byte = `UIED_IF_NUM;
         `UIED_IF_OFF_ALT: if_byte = `UIED_IF_ALT;
         `UIED_IF_OFF_NEP: if_byte = `UIED_IF_NEP;
         `UIED_IF_OFF_CLASS: if_byte = class_q;
         `UIED_IF_OFF_SUBCLASS: if_byte = subclass_q;
         `UIED_IF_OFF_PROTO: if_byte = proto_q;
         `UIED_IF_OFF_STRIDX: if_byte = stridx_q;
         default: if_byte = 8'h00;
      endcase
   end

   // Offsets relative to each endpoint window; only the low three bits are used.
   assign rel1 = idx_q - `UIED_EP1_BASE;
   assign rel2 = idx_q - `UIED_EP2_BASE;
   assign rel3 = idx_q - `UIED_EP3_BASE;

   // Bulk IN endpoint descriptor.
   uied_ep_byte u_ep1 (
      .offs(rel1[2:0]),
      .addr(`UIED_EP1_ADDR),
      .attr(`UIED_ATTR_BULK),
      .mps(bulk_mps),
      .ivl(`UIED_BULK_IVL),
      .data(ep1_byte)
   );

   // Bulk OUT endpoint descriptor.
   uied_ep_byte u_ep2 (
      .offs(rel2[2:0]),
      .addr(`UIED_EP2_ADDR),
      .attr(`UIED_ATTR_BULK),
      .mps(bulk_mps),
      .ivl(`UIED_BULK_IVL),
      .data(ep2_byte)
   );

   // Interrupt IN endpoint descriptor.
   uied_ep_byte u_ep3 (
      .offs(rel3[2:0]),
      .addr(`UIED_EP3_ADDR),
      .attr(`UIED_ATTR_INTR),
      .mps(`UIED_MPS_INTR),
      .ivl(intr_ivl),
      .data(ep3_byte)
   );

   // Byte mux over the concatenated response image.
   // Windows are tested in image order, so each test needs only an upper bound.
   always @* begin
      if (idx_q < `UIED_EP1_BASE) begin
         pick_d = if_byte;
      end else if (idx_q < `UIED_EP2_BASE) begin
         pick_d = ep1_byte;
      end else if (idx_q < `UIED_EP3_BASE) begin
         pick_d = ep2_byte;
      end else begin
         pick_d = ep3_byte;
      end
   end

   // Request pointer decode into a start and end byte within the image.
   always @* begin
      case (req_sel)
         `UIED_SEL_ALL: begin
            start_d = `UIED_IF_BASE;
            stop_d = `UIED_TOTAL;
         end
         `UIED_SEL_IF: begin
            start_d = `UIED_IF_BASE;
            stop_d = `UIED_EP1_BASE;
         end
         `UIED_SEL_EP1: begin
            start_d = `UIED_EP1_BASE;
            stop_d = `UIED_EP2_BASE;
         end
         `UIED_SEL_EP2: begin
            start_d = `UIED_EP2_BASE;
            stop_d = `UIED_EP3_BASE;
         end
         `UIED_SEL_EP3: begin
            start_d = `UIED_EP3_BASE;
            stop_d = `UIED_TOTAL;
         end
         // Unknown selectors give an empty window, so the request is dropped.
         default: begin
            start_d = `UIED_IF_BASE;
            stop_d = `UIED_IF_BASE;
         end
      endcase
      // A shorter host request length truncates the response.
      if (req_len != 6'h00 && (stop_d - start_d) > req_len) begin
         lim_d = start_d + req_len;
      end else begin
         lim_d = stop_d;
      end
      // Index of the byte after the one now being loaded.
      nidx_d = idx_q + 6'h01;
   end

   // Streaming engine: one byte per accepted handshake.
   always @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         busy_q <= 1'b0;
         idx_q <= 6'h00;
         end_q <= 6'h00;
         hs_q <= 1'b0;
         byte_valid <= 1'b0;
         byte_data <= 8'h00;
         byte_last <= 1'b0;
      end else if (!busy_q) begin
         // Idle: wait for a request that selects a nonzero length.
         byte_valid <= 1'b0;
         byte_last <= 1'b0;
         if (req_valid && lim_d != start_d) begin
            busy_q <= 1'b1;
            idx_q <= start_d;
            end_q <= lim_d;
            hs_q <= high_speed;
         end
      end else if (!byte_valid || byte_ready) begin
         // Busy: load a byte when none is shown or the shown one is taken.
         if (byte_valid && byte_last) begin
            // The last byte is taken; a new request is taken one edge later.
            busy_q <= 1'b0;
            byte_valid <= 1'b0;
            byte_last <= 1'b0;
         end else begin
            // Present the byte at the index and step to the next one.
            byte_valid <= 1'b1;
            byte_data <= pick_d;
            byte_last <= (nidx_d == end_q);
            idx_q <= nidx_d;
         end
      end
   end
endmodule

// *** uied_desc_chk.sv ***
`timescale 1ns/1ps
// Checks the descriptor byte stream at the top ports.
module uied_desc_chk (
   input wire clk,
   input wire sys_rst,
   input wire req_valid,
   input wire [2:0] req_sel,
   input wire [5:0] req_len,
   input wire byte_ready,
   input wire byte_valid,
   input wire [7:0] byte_data,
   input wire byte_last
);
   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);
   // A request that the idle source must take.
   wire go = !byte_valid && req_valid && req_sel < 3'h5;
   a_stall_hold: assert property (byte_valid && !byte_ready
      |=> byte_valid && $stable(byte_data)) else $error("stalled byte moved");
   a_end_idle: assert property (byte_valid && byte_ready && byte_last
      |=> !byte_valid) else $error("ran past last");
   // The first byte is sampled two edges after the edge that takes the request.
   a_first_byte: assert property (go
      |-> ##2 (byte_valid && byte_data == ($past(req_sel, 2) > 3'h1 ? 8'h07 : 8'h09)))
      else $error("bad first byte");
   a_bad_sel: assert property (!byte_valid && req_valid && req_sel > 3'h4
      |-> ##2 !byte_valid) else $error("bad select taken");
   a_one_byte: assert property (go && req_len == 6'h01
      |-> ##2 (byte_valid && byte_last)) else $error("short stream not last");
   a_rst_quiet: assert property (disable iff (1'b0) sys_rst
      |=> !byte_valid && !byte_last) else $error("output in reset");
   a_if_type: assert property ($rose(byte_valid) && byte_ready && !byte_last
      && byte_data == 8'h09 |=> byte_data == 8'h04) else $error("bad type");
   a_ep_type: assert property ($rose(byte_valid) && byte_ready && !byte_last
      && byte_data == 8'h07 |=> byte_data == 8'h05) else $error("bad type");
   // Main scenarios.
   c_stall: cover property (byte_valid && !byte_ready);
   c_last: cover property (byte_valid && byte_ready && byte_last);
   c_bad: cover property (req_valid && req_sel > 3'h4);
endmodule
bind uied_desc uied_desc_chk uied_desc_chk_inst (.clk, .sys_rst, .req_valid, .req_sel,
   .req_len, .byte_ready, .byte_valid, .byte_data, .byte_last);

// *** uied_host.sv ***
`timescale 1ns/1ps
// Far-side consumer; in slow mode it accepts every other cycle.
module uied_host (
   input wire clk,
   input wire slow,
   output reg byte_ready = 1'b0
);
   reg tog_q = 1'b0;
   // Ready steps after each rising edge.
   always @(posedge clk) begin
      tog_q <= !tog_q;
      byte_ready <= !slow || tog_q;
   end
endmodule

// *** uied_desc_tb.sv ***
`timescale 1ns/1ps
// Requests descriptors and checks each streamed byte.
module uied_desc_tb;
   reg clk = 1'b0;
   reg sys_rst = 1'b1;
   reg high_speed = 1'b0;
   reg ee_load = 1'b0;
   reg [47:0] ee = 48'hFF00FF000401;
   reg req_valid = 1'b0;
   reg [2:0] req_sel = 3'h0;
   reg [5:0] req_len = 6'h00;
   reg slow = 1'b0;
   wire byte_ready, byte_valid, byte_last;
   wire [7:0] byte_data;
   integer err_count = 0;
   integer comparisons = 0;
   integer t;
   reg [31:0] rows [0:7];
   uied_desc uied_desc_inst (.clk, .sys_rst, .high_speed, .ee_load, .ee_class(ee[47:40]),
      .ee_subclass(ee[39:32]), .ee_proto(ee[31:24]), .ee_stridx(ee[23:16]),
      .ee_ivl_hs(ee[15:8]), .ee_ivl_fs(ee[7:0]), .req_valid, .req_sel, .req_len,
      .byte_ready, .byte_valid, .byte_data, .byte_last);
   uied_host uied_host_inst (.clk, .slow, .byte_ready);
   // Clock with a 5 ns period.
   always #2.5 clk = !clk;
   task chk(input string nm, input [7:0] seen, input [7:0] exp);
      comparisons = comparisons + 1;
      if (seen !== exp) begin
         err_count = err_count + 1;
         $display("unexpected %s: expected %h seen %h", nm, exp, seen);
      end
   endtask
   task final_report;
      $display("comparisons %0d mismatches %0d", comparisons, err_count);
      if (err_count == 0 && comparisons > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   task req(input [2:0] s, input h, input [5:0] n);
      @(posedge clk);
      req_sel <= s;
      high_speed <= h;
      req_len <= n;
      req_valid <= 1'b1;
      @(posedge clk);
      req_valid <= 1'b0;
   endtask
   // Row: select, speed, length asked, first byte, bytes expected.
   task run(input [31:0] r);
      integer i, k;
      reg [15:0] m;
      reg [239:0] im;
      m = r[24] ? 16'h0002 : 16'h4000;
      im = {40'h0904000003, ee[47:16], 32'h07058102, m, 24'h000705, 16'h0202, m,
         40'h0007058303, 16'h1000, r[24] ? ee[15:8] : ee[7:0]};
      req(r[30:28], r[24], r[21:16]);
      for (i = 0; i < r[5:0]; i = i + 1) begin
         k = 0;
         #1;
         while (!(byte_valid && byte_ready) && k < 99) begin
            @(posedge clk);
            #1;
            k = k + 1;
         end
         chk("wait", {7'h00, k < 99}, 8'h01);
         chk("data", byte_data, im[239-8*(r[13:8]+i)-:8]);
         chk("last", {7'h00, byte_last}, {7'h00, i == r[5:0] - 1});
         @(posedge clk);
      end
      #1;
      chk("valid", {7'h00, byte_valid}, 8'h00);
      $display("test %h done", r);
   endtask
   // Reset, the table of cases, then the awkward cases.
   initial begin
      rows = '{32'h0000001E, 32'h0100001E, 32'h11000009, 32'h20000907, 32'h31001007,
         32'h40001707, 32'h00030003, 32'h41011701};
      repeat (12) @(posedge clk);
      sys_rst <= 1'b0;
      for (t = 0; t < 8; t = t + 1)
         run(rows[t]);
      @(posedge clk);
      ee <= 48'h0A0B0C0D2007;
      ee_load <= 1'b1;
      slow <= 1'b1;
      @(posedge clk);
      ee_load <= 1'b0;
      run(32'h0100001E);
      run(32'h40001707);
      req(3'h5, 1'b0, 6'h00);
      // A taken request would show its first byte after this edge.
      @(posedge clk);
      #1;
      chk("valid", {7'h00, byte_valid}, 8'h00);
      $display("test refuse done");
      req(3'h0, 1'b1, 6'h00);
      repeat (4) @(posedge clk);
      sys_rst <= 1'b1;
      ee <= 48'hFF00FF000401;
      @(posedge clk);
      sys_rst <= 1'b0;
      #1;
      chk("valid", {7'h00, byte_valid}, 8'h00);
      chk("last", {7'h00, byte_last}, 8'h00);
      $display("test reset done");
      run(32'h41001707);
      final_report;
   end
   // Watchdog cuts a hung run short.
   initial begin
      #50000;
      err_count = err_count + 1;
      final_report;
   end
endmodule
